// ### inc/aisp_cfg.svh
/*
 * Constants of the two-wire register port: address, counts, reset values.
 * Assumes nothing; included by the line conditioner and the register port.
 */
`ifndef AISP_CFG_SVH
`define AISP_CFG_SVH

// Fixed upper five bits of the seven-bit slave address
`define AISP_ADDR_FIXED 5'h1a
// Index of the last bit of a byte
`define AISP_BIT_LAST 3'h7
// Reset value of the register pointer
`define AISP_PTR_RST 8'h00
// Reset value of a register word
`define AISP_WORD_RST 16'h0000
// Reset value of a two-stage pipe
`define AISP_PIPE_RST 2'h0
// Reset value of a bus line pipe; the pulled-up lines idle high
`define AISP_LINE_PIPE_RST 2'h3
// Reset value of a delayed bus line copy
`define AISP_LINE_PREV_RST 1'h1
// Highest bus clock rate served, in kHz
`define AISP_SCL_MAX_KHZ 400
// Core clock rate, in kHz
`define AISP_CLK_KHZ 50000
// Core clocks per fastest bus clock period
`define AISP_CLKS_PER_SCL (`AISP_CLK_KHZ / `AISP_SCL_MAX_KHZ)

`endif

// ### inc/aisp_pkg.sv
/*
 * Types of the two-wire register port: protocol state and byte role.
 * Assumes the constants header sits beside it.
 */
`default_nettype none

package aisp_pkg;

    // Bit-level protocol state
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_RX,
        ST_RX_WAIT,
        ST_RX_ACK,
        ST_TX,
        ST_TX_WAIT,
        ST_TX_ACK,
        ST_TX_NEXT,
        ST_IGNORE
    } aisp_state_type;

    // Meaning of the next byte received
    typedef enum logic [1:0] {
        PH_ADDR,
        PH_PTR,
        PH_WR_MS,
        PH_WR_LS
    } aisp_phase_type;

endpackage : aisp_pkg

`default_nettype wire

// ### inc/aisp_line_if.sv
/*
 * Conditioned bus lines passed from the line conditioner to the core.
 * Assumes a single core clock drives both ends.
 */
`timescale 1ns/100ps
`default_nettype none

interface aisp_line_if;
    logic scl_rise; // Bus clock rising edge, one cycle
    logic scl_fall; // Bus clock falling edge, one cycle
    logic sda;      // Synchronised data line level
    logic start;    // Start or repeated start seen
    logic stop;     // Stop seen
    logic sel_hi;   // Upper address select level
    logic sel_lo;   // Lower address select level
    logic mode;     // Bus-controlled mode level

    // Producer side
    modport cond (output scl_rise, scl_fall, sda, start, stop, sel_hi, sel_lo, mode);
    // Consumer side
    modport core (input scl_rise, scl_fall, sda, start, stop, sel_hi, sel_lo, mode);
endinterface : aisp_line_if

`default_nettype wire

// ### src/aisp_line_cond.sv
/*
 * Line conditioner: synchronises pins and finds bus edges, start and stop.
 * Assumes a reset already synchronised to clk_i.
 */
`timescale 1ns/100ps
`default_nettype none

module aisp_line_cond
    import aisp_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic scl_pin_i,
    input wire logic sda_pin_i,
    input wire logic sel_hi_pin_i,
    input wire logic sel_lo_pin_i,
    input wire logic mode_pin_i,
    aisp_line_if.cond lines
);

    `include "aisp_cfg.svh"

    localparam int NUM_PINS = 5;

    logic [NUM_PINS-1:0] pin_raw;     // Raw pin levels
    logic [NUM_PINS-1:0] pin_sync;    // Second-stage outputs
    logic scl_prev_reg;               // Bus clock one cycle back
    logic sda_prev_reg;               // Bus data one cycle back

    assign pin_raw = {mode_pin_i, sel_lo_pin_i, sel_hi_pin_i, sda_pin_i, scl_pin_i};

    // Two flip-flops per pin; 125 samples per fastest bus period
    // oversampled bus clock
    for (genvar gi = 0; gi < NUM_PINS; gi++) begin : g_sync
        logic [1:0] pipe_reg; // Synchroniser pair
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                // Bus lines start at their idle level: no false edge
                pipe_reg <= (gi < 2) ? `AISP_LINE_PIPE_RST : `AISP_PIPE_RST;
            end else begin
                pipe_reg <= {pipe_reg[0], pin_raw[gi]};
            end
        end
        assign pin_sync[gi] = pipe_reg[1];
    end

    // Delayed copies for edge finding
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scl_prev_reg <= `AISP_LINE_PREV_RST;
            sda_prev_reg <= `AISP_LINE_PREV_RST;
        end else begin
            scl_prev_reg <= pin_sync[0];
            sda_prev_reg <= pin_sync[1];
        end
    end

    // Edges and bus conditions
    assign lines.scl_rise = pin_sync[0] & ~scl_prev_reg;
    assign lines.scl_fall = ~pin_sync[0] & scl_prev_reg;
    assign lines.sda = pin_sync[1];
    assign lines.start = pin_sync[0] & scl_prev_reg & sda_prev_reg & ~pin_sync[1];
    assign lines.stop = pin_sync[0] & scl_prev_reg & ~sda_prev_reg & pin_sync[1];
    assign lines.sel_hi = pin_sync[2];
    assign lines.sel_lo = pin_sync[3];
    assign lines.mode = pin_sync[4];

endmodule : aisp_line_cond

`default_nettype wire

// ### src/aisp_reg_port.sv
/*
 * Slave-only two-wire register port: addressing, pointer, word transfers.
 * Assumes reg_rdata_i shows the word at reg_addr_o combinationally.
 */
// What this block does
// - Serves bus clocks up to 400 kHz
// - Slave only, never drives the clock
// - Serves the bus only in bus mode
// - Answers address 11010 plus two straps
// - Upper strap is high bit, lower low
// - Registers move as 16-bit byte pairs
// - Bytes travel most significant bit first
// - Acknowledges address and pointer bytes
// - Writes high then low byte, commits both
// - Pointer advances after each written pair
// - Read by repeated start, direction one
// - Sends high byte, then low byte
// - Master acknowledge of the low byte advances to next register
// - Master no-acknowledge releases the data line
`timescale 1ns/100ps
`default_nettype none

module aisp_reg_port
    import aisp_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic bus_clock_or_freq_strap_pin_i,
    input wire logic bus_data_or_role_strap_pin_i,
    output logic bus_data_or_role_strap_pin_o,
    output logic bus_data_or_role_strap_pin_oe_o,
    input wire logic addr_select_hi_pin_i,
    input wire logic addr_select_lo_pin_i,
    input wire logic bus_ctrl_mode_i,
    input wire logic [15:0] reg_rdata_i,
    output logic [7:0] reg_addr_o,
    output logic [15:0] reg_wdata_o,
    output logic reg_wr_o,
    output logic reg_rd_o
);

    `include "aisp_cfg.svh"

    logic [1:0] rst_pipe_reg;         // Reset release pipe
    logic rst_n;                      // Synchronised reset
    aisp_state_type state_reg;        // Protocol state
    aisp_phase_type phase_reg;        // Role of next received byte
    logic [2:0] bit_cnt_reg;          // Bits of current byte seen
    logic [6:0] shift_reg;            // Received bits so far
    logic [15:0] tx_reg;              // Outgoing word, current bit on top
    logic sda_oe_reg;                 // Pulling the data line low
    logic read_dir_reg;               // Address byte asked for a read
    logic lsb_sel_reg;                // Sending the low byte
    logic inc_pend_reg;               // Pointer advance after this ack
    logic [7:0] ptr_reg;              // Register pointer
    logic [7:0] msb_hold_reg;         // High byte awaiting its partner
    logic [15:0] wdata_reg;           // Word to commit
    logic wr_reg;                     // Commit strobe
    logic rd_reg;                     // Word-taken strobe
    logic [7:0] rx_byte;              // Byte completed this cycle
    logic [6:0] own_addr;             // Our seven-bit address
    logic byte_done;                  // Eighth bit clocked in
    logic addr_hit;                   // Address byte names us
    logic ev_commit;                  // Low byte of a write arrived
    logic ev_ptr_load;                // Pointer byte arrived
    logic ev_load_word;               // New word enters the shifter
    logic ev_ptr_inc;                 // Pointer moves to next register
    logic master_ack;                 // Master pulled low in its ack slot

    aisp_line_if line_if ();

    // Reset: asserted at once, released after two clocks
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_pipe_reg <= `AISP_PIPE_RST;
        end else begin
            rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe_reg[1];

    // Pin synchronisers and bus condition finder
    aisp_line_cond u_line_cond (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .scl_pin_i(bus_clock_or_freq_strap_pin_i),
        .sda_pin_i(bus_data_or_role_strap_pin_i),
        .sel_hi_pin_i(addr_select_hi_pin_i),
        .sel_lo_pin_i(addr_select_lo_pin_i),
        .mode_pin_i(bus_ctrl_mode_i),
        .lines(line_if.cond)
    );

    assign own_addr = {`AISP_ADDR_FIXED, line_if.sel_hi, line_if.sel_lo};

    assign rx_byte = {shift_reg, line_if.sda};
    assign byte_done = (state_reg == ST_RX) && line_if.scl_rise && (bit_cnt_reg == `AISP_BIT_LAST);
    assign addr_hit = (rx_byte[7:1] == own_addr);
    assign master_ack = line_if.scl_rise && !line_if.sda;

    // Decoded byte events
    assign ev_commit = byte_done && (phase_reg == PH_WR_LS);
    assign ev_ptr_load = byte_done && (phase_reg == PH_PTR);
    // Word taken after the read address ack, and after each acked low byte
    assign ev_load_word = line_if.scl_fall
        && (((state_reg == ST_RX_ACK) && read_dir_reg) || ((state_reg == ST_TX_NEXT) && lsb_sel_reg));
    assign ev_ptr_inc = ((state_reg == ST_RX_ACK) && line_if.scl_fall && inc_pend_reg)
        || ((state_reg == ST_TX_ACK) && master_ack && lsb_sel_reg);

    // Receive shifter
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            shift_reg <= 7'h00;
        end else if ((state_reg == ST_RX) && line_if.scl_rise) begin
            shift_reg <= rx_byte[6:0];
        end
    end

    // Protocol state, bit count, data line drive, transmit shifter
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            phase_reg <= PH_ADDR;
            bit_cnt_reg <= 3'h0;
            sda_oe_reg <= 1'b0;
            tx_reg <= `AISP_WORD_RST;
            read_dir_reg <= 1'b0;
            lsb_sel_reg <= 1'b0;
            inc_pend_reg <= 1'b0;
        end else if (!line_if.mode) begin
            state_reg <= ST_IDLE;
            sda_oe_reg <= 1'b0;
        end else if (line_if.stop) begin
            // Stop ends any transfer
            state_reg <= ST_IDLE;
            sda_oe_reg <= 1'b0;
        end else if (line_if.start) begin
            state_reg <= ST_RX;
            phase_reg <= PH_ADDR;
            bit_cnt_reg <= 3'h0;
            sda_oe_reg <= 1'b0;
            read_dir_reg <= 1'b0;
            lsb_sel_reg <= 1'b0;
            inc_pend_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                // Waiting for a start
                ST_IDLE, ST_IGNORE: begin
                    sda_oe_reg <= 1'b0;
                end
                // Shifting a byte in
                ST_RX: begin
                    if (line_if.scl_rise) begin
                        bit_cnt_reg <= bit_cnt_reg + 3'h1;
                    end
                    if (byte_done) begin
                        unique case (phase_reg)
                            PH_ADDR: begin
                                state_reg <= addr_hit ? ST_RX_WAIT : ST_IGNORE;
                                read_dir_reg <= rx_byte[0];
                                phase_reg <= PH_PTR;
                            end
                            PH_PTR: begin
                                state_reg <= ST_RX_WAIT;
                                phase_reg <= PH_WR_MS;
                            end
                            PH_WR_MS: begin
                                state_reg <= ST_RX_WAIT;
                                phase_reg <= PH_WR_LS;
                            end
                            PH_WR_LS: begin
                                state_reg <= ST_RX_WAIT;
                                phase_reg <= PH_WR_MS;
                                inc_pend_reg <= 1'b1;
                            end
                        endcase
                    end
                end
                // Eighth clock high; ack starts at its fall
                ST_RX_WAIT: begin
                    if (line_if.scl_fall) begin
                        state_reg <= ST_RX_ACK;
                        sda_oe_reg <= 1'b1;
                    end
                end
                // Holding ack low through the ninth clock
                ST_RX_ACK: begin
                    if (line_if.scl_fall) begin
                        inc_pend_reg <= 1'b0;
                        bit_cnt_reg <= 3'h0;
                        if (read_dir_reg) begin
                            state_reg <= ST_TX;
                            tx_reg <= reg_rdata_i;
                            sda_oe_reg <= ~reg_rdata_i[15];
                        end else begin
                            state_reg <= ST_RX;
                            sda_oe_reg <= 1'b0;
                        end
                    end
                end
                // Shifting a byte out; next bit after each fall
                ST_TX: begin
                    if (line_if.scl_rise) begin
                        bit_cnt_reg <= bit_cnt_reg + 3'h1;
                        if (bit_cnt_reg == `AISP_BIT_LAST) begin
                            state_reg <= ST_TX_WAIT;
                        end
                    end else if (line_if.scl_fall) begin
                        tx_reg <= {tx_reg[14:0], 1'b0};
                        sda_oe_reg <= ~tx_reg[14];
                    end
                end
                // Last bit clocked; free the line for the master
                ST_TX_WAIT: begin
                    if (line_if.scl_fall) begin
                        tx_reg <= {tx_reg[14:0], 1'b0};
                        sda_oe_reg <= 1'b0;
                        state_reg <= ST_TX_ACK;
                    end
                end
                // Sampling the master's answer
                ST_TX_ACK: begin
                    if (line_if.scl_rise) begin
                        if (line_if.sda) begin
                            state_reg <= ST_IGNORE;
                        end else begin
                            state_reg <= ST_TX_NEXT;
                        end
                    end
                end
                // Ack clock high; next byte starts at its fall
                ST_TX_NEXT: begin
                    if (line_if.scl_fall) begin
                        state_reg <= ST_TX;
                        bit_cnt_reg <= 3'h0;
                        lsb_sel_reg <= ~lsb_sel_reg;
                        if (lsb_sel_reg) begin
                            tx_reg <= reg_rdata_i;
                            sda_oe_reg <= ~reg_rdata_i[15];
                        end else begin
                            sda_oe_reg <= ~tx_reg[15];
                        end
                    end
                end
            endcase
        end
    end

    // Register pointer: loaded by pointer byte, advanced per word
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ptr_reg <= `AISP_PTR_RST;
        end else if (ev_ptr_load) begin
            ptr_reg <= rx_byte;
        end else if (ev_ptr_inc) begin
            ptr_reg <= ptr_reg + 8'h01;
        end
    end

    // Register-side strobes and write word
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            msb_hold_reg <= 8'h00;
            wdata_reg <= `AISP_WORD_RST;
            wr_reg <= 1'b0;
            rd_reg <= 1'b0;
        end else begin
            if (byte_done && (phase_reg == PH_WR_MS)) begin
                msb_hold_reg <= rx_byte;
            end
            wr_reg <= ev_commit;
            if (ev_commit) begin
                wdata_reg <= {msb_hold_reg, rx_byte};
            end
            rd_reg <= ev_load_word;
        end
    end

    // Outputs; data pin only ever pulls low
    // open-drain, slave only
    assign bus_data_or_role_strap_pin_o = rst_pipe_reg[1] & 1'b0;
    assign bus_data_or_role_strap_pin_oe_o = sda_oe_reg;
    assign reg_addr_o = ptr_reg;
    assign reg_wdata_o = wdata_reg;
    assign reg_wr_o = wr_reg;
    assign reg_rd_o = rd_reg;

    chk_mode_off_quiet: assert property (@(posedge clk_i) disable iff (!rst_n)
        !line_if.mode |=> !sda_oe_reg && (state_reg == ST_IDLE))
        else $error("data line driven outside bus mode");

    chk_foreign_quiet: assert property (@(posedge clk_i) disable iff (!rst_n)
        (byte_done && (phase_reg == PH_ADDR) && !addr_hit) |=> !sda_oe_reg [*8])
        else $error("foreign address disturbed the data line");

    chk_ack_slot: assert property (@(posedge clk_i) disable iff (!rst_n)
        ((state_reg == ST_RX_WAIT) && line_if.scl_fall && line_if.mode && !line_if.start && !line_if.stop)
        |=> sda_oe_reg && (state_reg == ST_RX_ACK))
        else $error("byte not acknowledged");

    chk_pair_commit: assert property (@(posedge clk_i) disable iff (!rst_n)
        ev_commit |=> reg_wr_o && (reg_wdata_o == {$past(msb_hold_reg), $past(rx_byte)}) ##1 !reg_wr_o)
        else $error("write word not committed as a pair");

    chk_ptr_advance: assert property (@(posedge clk_i) disable iff (!rst_n)
        (ev_ptr_inc && !ev_ptr_load) |=> (ptr_reg == $past(ptr_reg) + 8'h01))
        else $error("pointer did not advance");

    chk_tx_msb_first: assert property (@(posedge clk_i) disable iff (!rst_n)
        (state_reg == ST_TX) |-> (sda_oe_reg == !tx_reg[15]))
        else $error("transmitted bit is not the top bit");

    chk_nack_release: assert property (@(posedge clk_i) disable iff (!rst_n)
        ((state_reg == ST_TX_ACK) && line_if.scl_rise && line_if.sda && line_if.mode && !line_if.stop)
        |=> (state_reg == ST_IGNORE) && !sda_oe_reg ##1 !sda_oe_reg)
        else $error("line held after master no-ack");

    chk_read_word: assert property (@(posedge clk_i) disable iff (!rst_n)
        ev_load_word && line_if.mode && !line_if.start && !line_if.stop
        |=> (tx_reg == $past(reg_rdata_i)) && reg_rd_o)
        else $error("read word not loaded");

    chk_restart_addr: assert property (@(posedge clk_i) disable iff (!rst_n)
        (line_if.start && line_if.mode && !line_if.stop) |=> (state_reg == ST_RX) && (phase_reg == PH_ADDR))
        else $error("start did not restart addressing");

    chk_pull_on_fall: assert property (@(posedge clk_i) disable iff (!rst_n)
        $rose(sda_oe_reg) |-> $past(line_if.scl_fall))
        else $error("data line pulled low while bus clock high");

endmodule : aisp_reg_port

`default_nettype wire

// ### verification/aisp_master_model.sv
/*
 * Bus master model: drives the bus clock and pulls the data line low.
 * Assumes the bench resolves the data line with a pull-up.
 */
`timescale 1ns/100ps
`default_nettype none

module aisp_master_model (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_oe_o
);
    // Bus idle: clock high and still, data released
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end

    // Quarter of a 160 ns bus clock period
    task automatic q;
        repeat (2) @(negedge clk_i);
    endtask : q

    // start or repeated start, data falls while clock high
    task automatic start;
        sda_oe_o = 1'b0;
        q();
        scl_o = 1'b1;
        q();
        sda_oe_o = 1'b1;
        q();
        scl_o = 1'b0;
        q();
    endtask : start

    // nine clocks, most significant bit first, bit 0 is the ack slot
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            sda_oe_o = ~tx[i];
            q();
            scl_o = 1'b1;
            q();
            rx[i] = sda_i;
            q();
            scl_o = 1'b0;
            q();
        end
    endtask : xfer

    // stop after the transfer, clock then stands still
    task automatic stop;
        sda_oe_o = 1'b1;
        q();
        scl_o = 1'b1;
        q();
        sda_oe_o = 1'b0;
        q();
        q();
    endtask : stop
endmodule : aisp_master_model

`default_nettype wire

// ### verification/amp_i2c_slave_reg_port_tb_top.sv
/*
 * Testbench of the register port: writes, reads, foreign address, mode off.
 * Assumes the master model beside it and a register array held here.
 */
`timescale 1ns/100ps
`default_nettype none

module amp_i2c_slave_reg_port_tb_top import aisp_pkg::*;;
    logic clk = 1'b0; // 50 MHz core clock
    logic rst_n = 1'b0; // Active low reset
    logic scl, mst_oe, dut_oe, pin_o, wr, rd; // Bus and strobe lines
    logic sel_hi = 1'b0, sel_lo = 1'b0, mode = 1'b1; // Straps and mode
    logic [7:0] addr; // Register pointer
    logic [15:0] wdata, rdata; // Register words
    logic [15:0] mem [256]; // Register array behind the port
    logic [15:0] shadow [256]; // Expected register contents
    int wr_cnt = 0, rd_cnt = 0, fails = 0, tests_run = 0, cycles = 0;
    wire sda = ~(dut_oe | mst_oe); // Pulled-up open-drain line

    always #10 clk = ~clk;
    assign rdata = mem[addr];

    aisp_master_model mst_u (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(mst_oe));
    aisp_reg_port dut_u (.clk_i(clk), .rst_n_i(rst_n), .bus_clock_or_freq_strap_pin_i(scl),
        .bus_data_or_role_strap_pin_i(sda), .bus_data_or_role_strap_pin_o(pin_o),
        .bus_data_or_role_strap_pin_oe_o(dut_oe), .addr_select_hi_pin_i(sel_hi),
        .addr_select_lo_pin_i(sel_lo), .bus_ctrl_mode_i(mode), .reg_rdata_i(rdata),
        .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd));

    // Register array takes each committed word; timeout guard
    always @(posedge clk) begin
        if (wr === 1'b1) begin
            mem[addr] <= wdata;
            wr_cnt++;
        end
        if (rd === 1'b1)
            rd_cnt++;
        cycles++;
        if (cycles == 30000) begin
            fails++;
            conclude();
        end
    end

    task automatic conclude;
        $display("comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Address byte with the ack slot released
    function automatic logic [8:0] dev(input logic [1:0] a, input logic r);
        return {5'h1a, a, r, 1'b1};
    endfunction : dev

    // Opens a write and loads the pointer
    task automatic open_wr(input logic [7:0] ptr);
        logic [8:0] rx;
        mst_u.start();
        mst_u.xfer(dev({sel_hi, sel_lo}, 1'b0), rx);
        check(16'(rx[0]), 16'h0000);
        mst_u.xfer({ptr, 1'b1}, rx);
        check(16'(rx[0]), 16'h0000);
    endtask : open_wr

    // Burst write, then each word checked in the array
    task automatic wr_words(input logic [7:0] ptr, input int n, input logic [15:0] w0);
        logic [8:0] rx;
        open_wr(ptr);
        for (int i = 0; i < n; i++) begin
            shadow[ptr + 8'(i)] = w0 + 16'(i);
            mst_u.xfer({shadow[ptr + 8'(i)][15:8], 1'b1}, rx);
            check(16'(rx[0]), 16'h0000);
            mst_u.xfer({shadow[ptr + 8'(i)][7:0], 1'b1}, rx);
            check(16'(rx[0]), 16'h0000);
        end
        mst_u.stop();
        for (int i = 0; i < n; i++)
            check(mem[ptr + 8'(i)], shadow[ptr + 8'(i)]);
    endtask : wr_words

    // Every strap setting answers its own address; last one wraps the pointer
    task automatic s_write;
        for (int k = 0; k < 4; k++) begin
            {sel_hi, sel_lo} = 2'(k);
            repeat (8) @(negedge clk);
            wr_words((k == 3) ? 8'hfe : 8'h20 + 8'(4 * k), 3, 16'h8001 + 16'(k * 16'h1111));
        end
    endtask : s_write

    // Pointer, repeated start, burst read ending in no-ack
    task automatic s_read(input logic [7:0] ptr, input int n);
        logic [8:0] rx;
        int r0;
        open_wr(ptr);
        r0 = rd_cnt;
        mst_u.start();
        mst_u.xfer(dev({sel_hi, sel_lo}, 1'b1), rx);
        check(16'(rx[0]), 16'h0000);
        for (int i = 0; i < n; i++) begin
            mst_u.xfer(9'h1fe, rx);
            check(16'(rx[8:1]), 16'(shadow[ptr + 8'(i)][15:8]));
            mst_u.xfer({8'hff, i == n - 1}, rx);
            check(16'(rx[8:1]), 16'(shadow[ptr + 8'(i)][7:0]));
        end
        mst_u.q();
        check(16'(dut_oe), 16'h0000);
        mst_u.stop();
        check(16'(rd_cnt - r0), 16'(n));
    endtask : s_read

    // Foreign addresses draw no ack and commit nothing
    task automatic s_foreign;
        logic [8:0] rx;
        int n0;
        n0 = wr_cnt;
        for (int k = 0; k < 2; k++) begin
            mst_u.start();
            mst_u.xfer((k == 0) ? dev(~{sel_hi, sel_lo}, 1'b0) : {7'h5b, 2'b01}, rx);
            check(16'(rx[0]), 16'h0001);
            repeat (3) mst_u.xfer(9'h001, rx);
            check(16'(rx[0]), 16'h0001);
            mst_u.stop();
        end
        check(16'(wr_cnt - n0), 16'h0000);
    endtask : s_foreign

    // One byte then stop leaves the register alone
    task automatic s_half;
        logic [8:0] rx;
        int n0;
        n0 = wr_cnt;
        open_wr(8'h40);
        mst_u.xfer(9'h0ab, rx);
        mst_u.stop();
        check(16'(wr_cnt - n0), 16'h0000);
        check(mem[8'h40], shadow[8'h40]);
    endtask : s_half

    // Port idle outside bus mode
    task automatic s_mode;
        logic [8:0] rx;
        mode = 1'b0;
        repeat (6) @(negedge clk);
        mst_u.start();
        mst_u.xfer(dev({sel_hi, sel_lo}, 1'b0), rx);
        check(16'(rx[0]), 16'h0001);
        mst_u.stop();
        mode = 1'b1;
        repeat (8) @(negedge clk);
    endtask : s_mode

    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 16'(i * 16'h0101) ^ 16'h5aa5;
            shadow[i] = mem[i];
        end
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        repeat (8) @(negedge clk);
        s_write();
        s_read(8'hfe, 3);
        s_read(8'h2c, 1);
        s_foreign();
        s_half();
        s_mode();
        s_read(8'h24, 2);
        check(16'(pin_o), 16'h0000);
        conclude();
    end
endmodule : amp_i2c_slave_reg_port_tb_top

`default_nettype wire
